/* verilog/occ_pkg.sv */
// Constants, types and register map of the four-channel output compare block
// Behaviour
// - Four channels, each with its own control register
// - Idle-stop bit 13 halts channel during idle
// - Fault bit 4 set by hardware, read-only
// - Fault bit used only in mode 111
// - Bit 3 picks third timer, else second
// - Mode 111: PWM with fault input watched
// - Mode 110: PWM, fault input ignored
// - Mode 101: start low, continuous pulse train
// - Mode 100: start low, one single pulse
// - Mode 011: each compare event toggles output
// - Mode 010: start high, event forces low
// - Mode 001: start low, event forces high
// - Mode 000: channel disabled, output quiet
package occ_pkg;

  // Channel count and data widths
  localparam int OCC_NUM_CH  = 4;
  localparam int OCC_CNT_W   = 16;
  localparam int OCC_ADDR_W  = 8;
  localparam int OCC_DATA_W  = 32;

  // Byte addresses: channel n at n * stride
  localparam logic [OCC_ADDR_W-1:0] OCC_CH_STRIDE  = 8'h10;
  localparam logic [OCC_ADDR_W-1:0] OCC_OFF_CTRL   = 8'h00;
  localparam logic [OCC_ADDR_W-1:0] OCC_OFF_CMP    = 8'h04;
  localparam logic [OCC_ADDR_W-1:0] OCC_OFF_CMP2   = 8'h08;
  localparam logic [OCC_ADDR_W-1:0] OCC_OFF_STATUS = 8'h40;

  // Control register field positions
  localparam int OCC_IDLE_BIT = 13;
  localparam int OCC_FLT_BIT  = 4;
  localparam int OCC_TSEL_BIT = 3;
  localparam int OCC_MODE_LSB = 0;
  localparam int OCC_MODE_W   = 3;

  // Reset values
  localparam logic [OCC_CNT_W-1:0]  OCC_CNT_RST  = 16'h0000;
  localparam logic [OCC_DATA_W-1:0] OCC_DATA_RST = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] OCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] OCC_RESP_SLVERR = 2'h2;

  // Register selector within a channel
  localparam logic [1:0] OCC_SEL_CTRL = 2'h0;
  localparam logic [1:0] OCC_SEL_CMP  = 2'h1;
  localparam logic [1:0] OCC_SEL_CMP2 = 2'h2;
  localparam logic [1:0] OCC_SEL_STAT = 2'h3;

  // Compare modes
  typedef enum logic [2:0] {
    OCC_MODE_OFF    = 3'b000,
    OCC_MODE_SET    = 3'b001,
    OCC_MODE_CLR    = 3'b010,
    OCC_MODE_TOG    = 3'b011,
    OCC_MODE_SINGLE = 3'b100,
    OCC_MODE_TRAIN  = 3'b101,
    OCC_MODE_PWM    = 3'b110,
    OCC_MODE_PWMF   = 3'b111
  } occ_mode_t;

  // Pulse sequencer states
  typedef enum logic [1:0] {
    OCC_ST_IDLE = 2'b00,
    OCC_ST_RISE = 2'b01,
    OCC_ST_FALL = 2'b10,
    OCC_ST_DONE = 2'b11
  } occ_state_t;

  // Software control fields of one channel
  typedef struct packed {
    logic      idle_stop;
    logic      tsel;
    occ_mode_t mode;
  } occ_ctrl_t;

  // One system timer as seen by the channels
  typedef struct packed {
    logic [OCC_CNT_W-1:0] count;
    logic                 period;
  } occ_timer_t;

endpackage : occ_pkg

/* verilog/occ_channel.sv */
// One output compare channel: mode sequencer, PWM and fault latch
`timescale 1ns/1ps
module occ_channel
  import occ_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  // Control from the register file
  input  wire occ_ctrl_t            ctrl_i,
  input  wire logic                 mode_wr_i,
  input  wire logic [OCC_CNT_W-1:0] cmp_i,
  input  wire logic [OCC_CNT_W-1:0] cmp2_i,
  // Timer bases, idle and fault
  input  wire occ_timer_t           tmr2_i,
  input  wire occ_timer_t           tmr3_i,
  input  wire logic                 idle_i,
  input  wire logic                 fault_i,
  // Pin and status
  output logic                      out_o,
  output logic                      fault_flag_o
);

  logic                 out_reg;
  logic                 out_next;
  logic                 flag_reg;
  logic                 flag_next;
  occ_state_t           state_reg;
  occ_state_t           state_next;
  logic                 eq_prev_reg;
  logic                 eq2_prev_reg;
  logic [OCC_CNT_W-1:0] duty_reg;
  logic [OCC_CNT_W-1:0] duty_next;

  wire occ_timer_t tb = ctrl_i.tsel ? tmr3_i : tmr2_i;
  // equality edges, one event per match
  wire eq    = (tb.count == cmp_i);
  wire eq2   = (tb.count == cmp2_i);
  wire hit   = eq & ~eq_prev_reg;
  wire hit2  = eq2 & ~eq2_prev_reg;
  wire eqd   = (tb.count == duty_reg);
  // halt while idle when idle-stop set
  wire run   = ~(ctrl_i.idle_stop & idle_i);
  wire pulse = (ctrl_i.mode == OCC_MODE_SINGLE) | (ctrl_i.mode == OCC_MODE_TRAIN);
  wire pwmf  = (ctrl_i.mode == OCC_MODE_PWMF);

  // Next-state logic for pin, sequencer and fault flag
  always_comb begin
    out_next   = out_reg;
    flag_next  = flag_reg;
    state_next = state_reg;
    duty_next  = duty_reg;
    if (mode_wr_i) begin
      // start high in mode 010, start low otherwise
      out_next   = (ctrl_i.mode == OCC_MODE_CLR);
      state_next = pulse ? OCC_ST_RISE : OCC_ST_IDLE;
      // hardware clear on mode rewrite; a live fault wins in mode 111
      flag_next  = pwmf & fault_i;
    end else if (run) begin
      case (ctrl_i.mode)
        OCC_MODE_OFF: out_next = 1'b0;
        OCC_MODE_SET: if (hit) out_next = 1'b1;
        OCC_MODE_CLR: if (hit) out_next = 1'b0;
        OCC_MODE_TOG: if (hit) out_next = ~out_reg;
        // rise on first value, fall on second
        OCC_MODE_SINGLE, OCC_MODE_TRAIN: begin
          if (state_reg == OCC_ST_RISE && hit) begin
            out_next   = 1'b1;
            state_next = OCC_ST_FALL;
          end else if (state_reg == OCC_ST_FALL && hit2) begin
            out_next   = 1'b0;
            state_next = (ctrl_i.mode == OCC_MODE_TRAIN) ? OCC_ST_RISE : OCC_ST_DONE;
          end
        end
        // high from period start until duty match
        OCC_MODE_PWM, OCC_MODE_PWMF: begin
          if (tb.period) begin
            duty_next = cmp_i;
            out_next  = (cmp_i != OCC_CNT_RST);
          end else if (eqd) begin
            out_next = 1'b0;
          end
          // fault only watched in mode 111
          if (pwmf & (fault_i | flag_reg)) begin
            flag_next = 1'b1;
            out_next  = 1'b0;
          end
        end
        default: out_next = 1'b0;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_reg      <= 1'b0;
      flag_reg     <= 1'b0;
      state_reg    <= OCC_ST_IDLE;
      duty_reg     <= OCC_CNT_RST;
      eq_prev_reg  <= 1'b0;
      eq2_prev_reg <= 1'b0;
    end else begin
      out_reg      <= out_next;
      flag_reg     <= flag_next;
      state_reg    <= state_next;
      duty_reg     <= duty_next;
      eq_prev_reg  <= run ? eq : eq_prev_reg;
      eq2_prev_reg <= run ? eq2 : eq2_prev_reg;
    end
  end

  assign out_o        = out_reg;
  assign fault_flag_o = flag_reg;

endmodule : occ_channel

/* verilog/occ_top.sv */
// Four-channel output compare block with AXI4-Lite register slave
`timescale 1ns/1ps
module occ_top
  import occ_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // AXI4-Lite write address
  input  wire logic [OCC_ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                    s_axi_awvalid_i,
  output logic                         s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [OCC_DATA_W-1:0]   s_axi_wdata_i,
  input  wire logic [3:0]              s_axi_wstrb_i,
  input  wire logic                    s_axi_wvalid_i,
  output logic                         s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp_o,
  output logic                         s_axi_bvalid_o,
  input  wire logic                    s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [OCC_ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                    s_axi_arvalid_i,
  output logic                         s_axi_arready_o,
  // AXI4-Lite read data
  output logic [OCC_DATA_W-1:0]        s_axi_rdata_o,
  output logic [1:0]                   s_axi_rresp_o,
  output logic                         s_axi_rvalid_o,
  input  wire logic                    s_axi_rready_i,
  // Timer bases
  input  wire logic [OCC_CNT_W-1:0]    second_system_timer_count_i,
  input  wire logic                    second_system_timer_period_i,
  input  wire logic [OCC_CNT_W-1:0]    third_system_timer_count_i,
  input  wire logic                    third_system_timer_period_i,
  // Processor idle and shared fault input
  input  wire logic                    cpu_idle_i,
  input  wire logic                    fault_i,
  // Compare pins and fault flags
  output logic [OCC_NUM_CH-1:0]        compare_output_pin_o,
  output logic [OCC_NUM_CH-1:0]        pwm_fault_flag_o
);

  // Register file: one control, compare and second compare word per channel
  occ_ctrl_t            compare_channel_control_reg [OCC_NUM_CH];
  logic [OCC_CNT_W-1:0] cmp_reg                     [OCC_NUM_CH];
  logic [OCC_CNT_W-1:0] cmp2_reg                    [OCC_NUM_CH];
  logic [OCC_NUM_CH-1:0] mode_wr_reg;
  logic [OCC_NUM_CH-1:0] pin_w;
  logic [OCC_NUM_CH-1:0] flag_w;

  // Write channel holding registers
  logic                  aw_full_reg;
  logic [OCC_ADDR_W-1:0] aw_addr_reg;
  logic                  w_full_reg;
  logic [OCC_DATA_W-1:0] w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  awready_reg;
  logic                  wready_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;

  // Read channel registers
  logic                  arready_reg;
  logic                  rvalid_reg;
  logic [OCC_DATA_W-1:0] rdata_reg;
  logic [1:0]            rresp_reg;

  // Status mirror registers driving the pins
  logic [OCC_NUM_CH-1:0] pin_reg;
  logic [OCC_NUM_CH-1:0] flag_reg;

  // Address decode result
  typedef struct packed {
    logic       hit;
    logic [1:0] ch;
    logic [1:0] sel;
  } occ_dec_t;

  // Decode a byte address into channel and register; shared by reads and writes
  function automatic occ_dec_t occ_decode(input logic [OCC_ADDR_W-1:0] addr);
    occ_dec_t d;
    logic [OCC_ADDR_W-1:0] off;
    d     = '0;
    off   = addr & (OCC_CH_STRIDE - 8'h01);
    d.ch  = addr[5:4];
    if (addr == OCC_OFF_STATUS) begin
      d.hit = 1'b1;
      d.sel = OCC_SEL_STAT;
    end else if (addr < OCC_OFF_STATUS) begin
      if (off == OCC_OFF_CTRL) begin
        d.hit = 1'b1;
        d.sel = OCC_SEL_CTRL;
      end else if (off == OCC_OFF_CMP) begin
        d.hit = 1'b1;
        d.sel = OCC_SEL_CMP;
      end else if (off == OCC_OFF_CMP2) begin
        d.hit = 1'b1;
        d.sel = OCC_SEL_CMP2;
      end
    end
    return d;
  endfunction : occ_decode

  // Merge byte lanes of a 16-bit register
  function automatic logic [OCC_CNT_W-1:0] occ_merge(
    input logic [OCC_CNT_W-1:0]  old,
    input logic [OCC_DATA_W-1:0] data,
    input logic [3:0]            strb
  );
    logic [OCC_CNT_W-1:0] v;
    v = old;
    if (strb[0]) v[7:0]  = data[7:0];
    if (strb[1]) v[15:8] = data[15:8];
    return v;
  endfunction : occ_merge

  // Write commits once both address and data are held and no response waits
  wire       wr_go  = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire occ_dec_t wr_dec = occ_decode(aw_addr_reg);
  // Status register is read-only; writes to it answer OKAY and change nothing
  wire       wr_reg = wr_go & wr_dec.hit & (wr_dec.sel != OCC_SEL_STAT);

  // Read decode on the offered address
  wire       rd_go  = s_axi_arvalid_i & arready_reg;
  wire occ_dec_t rd_dec = occ_decode(s_axi_araddr_i);

  // Control word as software sees it, fault flag in bit 4
  logic [OCC_DATA_W-1:0] ctrl_view [OCC_NUM_CH];

  // Read data selection
  logic [OCC_DATA_W-1:0] rd_word;
  always_comb begin
    rd_word = OCC_DATA_RST;
    case (rd_dec.sel)
      OCC_SEL_CTRL: rd_word = ctrl_view[rd_dec.ch];
      OCC_SEL_CMP:  rd_word = {16'h0000, cmp_reg[rd_dec.ch]};
      OCC_SEL_CMP2: rd_word = {16'h0000, cmp2_reg[rd_dec.ch]};
      OCC_SEL_STAT: rd_word = {24'h00_0000, flag_reg, pin_reg};
      default:      rd_word = OCC_DATA_RST;
    endcase
  end

  // AXI write address and data capture, accepted in either order
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      awready_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= OCC_DATA_RST;
      w_strb_reg  <= 4'h0;
      wready_reg  <= 1'b0;
    end else begin
      // Readies stay low while a response waits, so no second write slips in
      awready_reg <= ~aw_full_reg & ~(s_axi_awvalid_i & awready_reg) & ~wr_go & ~bvalid_reg;
      wready_reg  <= ~w_full_reg & ~(s_axi_wvalid_i & wready_reg) & ~wr_go & ~bvalid_reg;
      if (s_axi_awvalid_i & awready_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid_i & wready_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // AXI write response; unmapped address answers SLVERR
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= OCC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_dec.hit ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
    end else if (bvalid_reg & s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // AXI read channel: one read at a time, data held until rready
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= OCC_DATA_RST;
      rresp_reg   <= OCC_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_reg & ~rd_go;
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_dec.hit ? rd_word : OCC_DATA_RST;
        rresp_reg  <= rd_dec.hit ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Shared timer views
  wire occ_timer_t tmr2 = '{count: second_system_timer_count_i,
                            period: second_system_timer_period_i};
  wire occ_timer_t tmr3 = '{count: third_system_timer_count_i,
                            period: third_system_timer_period_i};

  // four identical channels, each with its own registers
  genvar gi;
  generate
    for (gi = 0; gi < OCC_NUM_CH; gi++) begin : g_ch
      wire hit_ch = wr_reg & (wr_dec.ch == 2'(gi));

      // Per-channel register writes; mode change pulses the sequencer
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          compare_channel_control_reg[gi] <= '{idle_stop: 1'b0, tsel: 1'b0,
                                               mode: OCC_MODE_OFF};
          cmp_reg[gi]     <= OCC_CNT_RST;
          cmp2_reg[gi]    <= OCC_CNT_RST;
          mode_wr_reg[gi] <= 1'b0;
        end else begin
          mode_wr_reg[gi] <= hit_ch & (wr_dec.sel == OCC_SEL_CTRL) & w_strb_reg[0];
          if (hit_ch & (wr_dec.sel == OCC_SEL_CTRL)) begin
            // idle-stop sits in the upper byte lane
            if (w_strb_reg[1]) begin
              compare_channel_control_reg[gi].idle_stop <= w_data_reg[OCC_IDLE_BIT];
            end
            // timer select and mode in the lower byte lane
            if (w_strb_reg[0]) begin
              compare_channel_control_reg[gi].tsel <= w_data_reg[OCC_TSEL_BIT];
              compare_channel_control_reg[gi].mode <=
                occ_mode_t'(w_data_reg[OCC_MODE_LSB +: OCC_MODE_W]);
            end
          end
          if (hit_ch & (wr_dec.sel == OCC_SEL_CMP)) begin
            cmp_reg[gi] <= occ_merge(cmp_reg[gi], w_data_reg, w_strb_reg);
          end
          if (hit_ch & (wr_dec.sel == OCC_SEL_CMP2)) begin
            cmp2_reg[gi] <= occ_merge(cmp2_reg[gi], w_data_reg, w_strb_reg);
          end
        end
      end

      // fault bit reads from hardware only, never written
      assign ctrl_view[gi] = {18'h0_0000,
                              compare_channel_control_reg[gi].idle_stop,
                              8'h00,
                              flag_w[gi],
                              compare_channel_control_reg[gi].tsel,
                              compare_channel_control_reg[gi].mode};

      // Channel core
      occ_channel u_channel (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .ctrl_i       (compare_channel_control_reg[gi]),
        .mode_wr_i    (mode_wr_reg[gi]),
        .cmp_i        (cmp_reg[gi]),
        .cmp2_i       (cmp2_reg[gi]),
        .tmr2_i       (tmr2),
        .tmr3_i       (tmr3),
        .idle_i       (cpu_idle_i),
        .fault_i      (fault_i),
        .out_o        (pin_w[gi]),
        .fault_flag_o (flag_w[gi])
      );
    end
  endgenerate

  // Pin and flag outputs retimed so every top output leaves a flip-flop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_reg  <= '0;
      flag_reg <= '0;
    end else begin
      pin_reg  <= pin_w;
      flag_reg <= flag_w;
    end
  end

  // Output drive
  assign s_axi_awready_o      = awready_reg;
  assign s_axi_wready_o       = wready_reg;
  assign s_axi_bvalid_o       = bvalid_reg;
  assign s_axi_bresp_o        = bresp_reg;
  assign s_axi_arready_o      = arready_reg;
  assign s_axi_rvalid_o       = rvalid_reg;
  assign s_axi_rdata_o        = rdata_reg;
  assign s_axi_rresp_o        = rresp_reg;
  assign compare_output_pin_o = pin_reg;
  assign pwm_fault_flag_o     = flag_reg;

endmodule : occ_top

/* tb/occ_far_end.sv */
// Far-side model: fault source and load on the compare pins
`timescale 1ns/1ps
module occ_far_end
  import occ_pkg::*;
(
  // Clock and command from the bench
  input  wire logic                  clk_i,
  input  wire logic                  fault_req_i,
  // Pins driving the load
  input  wire logic [OCC_NUM_CH-1:0] pin_i,
  // Fault line back to the block
  output logic                       fault_o = 1'b0
);
  logic [OCC_NUM_CH-1:0] load_reg;

  // Fault moves on an edge only, like a synchronised board signal
  always @(posedge clk_i) begin
    fault_o  <= fault_req_i;
    load_reg <= pin_i;
  end
endmodule : occ_far_end

/* tb/occ_top_sva.sv */
// Assertions on bus handshakes, fault flags and pins of the compare block
`timescale 1ns/1ps
module occ_top_sva
  import occ_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  // Bus handshakes
  input wire logic                  s_axi_awvalid_i,
  input wire logic                  s_axi_awready_o,
  input wire logic                  s_axi_wvalid_i,
  input wire logic                  s_axi_wready_o,
  input wire logic [1:0]            s_axi_bresp_o,
  input wire logic                  s_axi_bvalid_o,
  input wire logic                  s_axi_bready_i,
  input wire logic                  s_axi_arvalid_i,
  input wire logic                  s_axi_arready_o,
  input wire logic [OCC_DATA_W-1:0] s_axi_rdata_o,
  input wire logic                  s_axi_rvalid_o,
  input wire logic                  s_axi_rready_i,
  // Fault input, pins and flags
  input wire logic                  fault_i,
  input wire logic [OCC_NUM_CH-1:0] compare_output_pin_o,
  input wire logic [OCC_NUM_CH-1:0] pwm_fault_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Answers come in time and stand until taken; no new request is taken meanwhile
  AST_B_STANDS:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
                     s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_R_STANDS:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
                     s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  AST_RD_ANSWER:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered next cycle");
  AST_WR_ANSWER:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                     |-> ##[1:2] s_axi_bvalid_o)
    else $error("write not answered in time");
  AST_RD_BLOCK:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  AST_WR_BLOCK:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  // Flag rises only after the fault line, falls only after a write
  AST_FLT_RISE:
    assert property ((pwm_fault_flag_o & ~$past(pwm_fault_flag_o)) != '0 |->
                     $past(fault_i) || $past(fault_i, 2) || $past(fault_i, 3))
    else $error("fault flag set without fault input");
  AST_FLT_FALL:
    assert property ((~pwm_fault_flag_o & $past(pwm_fault_flag_o)) != '0 |->
                     $past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2) ||
                     $past(s_axi_bvalid_o, 3) || $past(s_axi_bvalid_o, 4))
    else $error("fault flag cleared without a write");
  AST_FLT_PIN:
    assert property (($past(pwm_fault_flag_o, 3) & pwm_fault_flag_o & compare_output_pin_o) == '0)
    else $error("pin high while fault latched");

  // Main scenarios reached
  COV_WRITE: cover property (s_axi_bvalid_o && s_axi_bready_i);
  COV_READ:  cover property (s_axi_rvalid_o && s_axi_rready_i);
  COV_FAULT: cover property ($rose(pwm_fault_flag_o[0]));
endmodule : occ_top_sva

bind occ_top occ_top_sva i_sva (.clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .fault_i, .compare_output_pin_o, .pwm_fault_flag_o);

/* tb/tb.sv */
// Self-checking bench for the four-channel output compare block
`timescale 1ns/1ps
module tb;
  import occ_pkg::*;
  localparam int LIMIT = 20000;
  // Check points: edge modes, pulse modes, PWM, third timer
  localparam logic [63:0] PT_EDGE  = 64'h000c_0032_000c_0032;
  localparam logic [63:0] PT_PULSE = 64'h000c_0019_0028_0019;
  localparam logic [63:0] PT_PWM   = 64'h0032_000a_0032_000a;
  localparam logic [63:0] PT_T3    = 64'h000c_005a_006e_000c;
  logic        clk_i = 1'b0, reset_i = 1'b1, cpu_idle_i = 1'b0, fault_req = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
  logic [31:0] s_axi_rdata_o, d;
  logic [15:0] t2 = 16'h0000, t3 = 16'h0000;
  logic        fault_i;
  logic [3:0]  compare_output_pin_o, pwm_fault_flag_o;
  int          n_fail = 0, checks_done = 0, cyc = 0;

  always #10 clk_i = ~clk_i;

  // Time bases of 64 and 128 counts, plus hang guard
  always @(posedge clk_i) begin
    t2 <= (t2 == 16'h003f) ? 16'h0000 : t2 + 16'h0001;
    t3 <= (t3 == 16'h007f) ? 16'h0000 : t3 + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  occ_top i_dut (.clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .second_system_timer_count_i(t2), .second_system_timer_period_i(t2 == 16'h0000),
    .third_system_timer_count_i(t3), .third_system_timer_period_i(t3 == 16'h0000),
    .cpu_idle_i, .fault_i, .compare_output_pin_o, .pwm_fault_flag_o);

  occ_far_end i_far (.clk_i, .fault_req_i(fault_req), .pin_i(compare_output_pin_o),
    .fault_o(fault_i));

  task automatic summarize();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    s_axi_awaddr_i <= a; s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1; s_axi_wvalid_i <= 1'b1; s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a; s_axi_arvalid_i <= 1'b1; s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : rd

  task automatic wait_t(input logic sel, input logic [15:0] v);
    do @(posedge clk_i); while ((sel ? t3 : t2) != v);
  endtask : wait_t

  // Program one channel at count zero, then sample its pin at four counts
  task automatic run(input logic [7:0] ch, input logic [15:0] ctl, c1, c2,
                     input logic [63:0] p, input logic [3:0] e);
    wr(ch * OCC_CH_STRIDE + OCC_OFF_CMP, {16'h0000, c1});
    wr(ch * OCC_CH_STRIDE + OCC_OFF_CMP2, {16'h0000, c2});
    wait_t(ctl[3], 16'h0000);
    wr(ch * OCC_CH_STRIDE, {16'h0000, ctl});
    for (int i = 0; i < 4; i++) begin
      wait_t(ctl[3], p[63-16*i -: 16]);
      chk(compare_output_pin_o[ch], e[3-i]);
    end
  endtask : run

  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    // Reset values, field access, unmapped and status places
    for (int n = 0; n < 4; n++) begin
      rd(OCC_CH_STRIDE * 8'(n));
      chk(d, 32'h0000_0000);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10);
    chk(d, 32'h0000_200f);
    // Upper lane only: idle-stop cleared, timer select and mode kept
    s_axi_wstrb_i <= 4'h2;
    wr(8'h10, 32'h0000_0000);
    s_axi_wstrb_i <= 4'hf;
    rd(8'h10);
    chk(d, 32'h0000_000f);
    rd(8'h50);
    chk({d[3:0], r}, {4'h0, OCC_RESP_SLVERR});
    wr(8'h50, 32'h0000_0001);
    chk(r, OCC_RESP_SLVERR);
    wr(OCC_OFF_STATUS, 32'h0000_00ff);
    chk(r, OCC_RESP_OKAY);
    // Modes 000 to 110, spread over the channels
    run(0, 16'h0001, 16'h0028, 16'h0000, PT_EDGE, 4'b0111);
    run(1, 16'h0002, 16'h0028, 16'h0000, PT_EDGE, 4'b1000);
    run(2, 16'h0003, 16'h0028, 16'h0000, PT_EDGE, 4'b0110);
    run(3, 16'h0000, 16'h0028, 16'h0000, PT_EDGE, 4'b0000);
    run(1, 16'h0004, 16'h0014, 16'h001e, PT_PULSE, 4'b0100);
    run(2, 16'h0005, 16'h0014, 16'h001e, PT_PULSE, 4'b0101);
    run(0, 16'h0009, 16'h0064, 16'h0000, PT_T3, 4'b0011);
    fault_req <= 1'b1;
    run(3, 16'h0006, 16'h0020, 16'h0000, PT_PWM, 4'b0101);
    chk(pwm_fault_flag_o, 4'h0);
    fault_req <= 1'b0;
    cpu_idle_i <= 1'b1;
    run(1, 16'h2003, 16'h0028, 16'h0000, PT_EDGE, 4'b0000);
    run(2, 16'h0003, 16'h0028, 16'h0000, PT_EDGE, 4'b0110);
    cpu_idle_i <= 1'b0;
    // Fault in guarded PWM: pin low, flag sticky, cleared by a mode rewrite once the fault is gone
    run(0, 16'h0007, 16'h0020, 16'h0000, PT_PWM, 4'b0101);
    fault_req <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({compare_output_pin_o[0], pwm_fault_flag_o[0]}, 2'b01);
    rd(OCC_OFF_CTRL);
    chk(d, 32'h0000_0017);
    rd(OCC_OFF_STATUS);
    chk(d[7:4], 4'h1);
    wr(OCC_OFF_CTRL, 32'h0000_0007);
    repeat (6) @(posedge clk_i);
    chk(pwm_fault_flag_o[0], 1'b1);
    fault_req <= 1'b0;
    wr(OCC_OFF_CTRL, 32'h0000_0007);
    repeat (6) @(posedge clk_i);
    chk(pwm_fault_flag_o[0], 1'b0);
    wr(OCC_OFF_CTRL, 32'h0000_0017);
    rd(OCC_OFF_CTRL);
    chk(d, 32'h0000_0007);
    summarize();
  end
endmodule : tb
